// File: src/pio_adapter.sv
// Dual port parallel I/O adapter: bus slave, ports and event flags
// Operation
// - Control bit 2 picks output or direction
// - Two select bits pick one of four slots
// - Control, direction, output writable; control, direction readable
// - Direction 1 drives output bit, 0 input
// - Side A slot read returns pin levels
// - Side B read mixes outputs and pins
// - Side B input lines leave driver off
// - Open-drain active-low request per side
// - First A input edge sets bit 7
// - Second A line edge sets bit 6 while bit 5 is clear
// - Side A slot read with bit 2 set (output) clears A flags
// - Side B edges set bits 7, 6; bit 6 only while bit 5 is clear
// - Side B slot read with bit 2 set (output) clears B flags
// - Request from flag and enable pairs
// - Bits 1, 4 choose falling or rising
// - Low reset input clears all registers
// - Respond only when selects are valid
// - Writes latched in phi2, applied after fall
`timescale 1ns/1ps
`default_nettype none

module pio_adapter
  import pio_adapter_pkg::*;
#(
  parameter int PORT_W = 8
) (
  input wire logic mclk_i,
  input wire logic reset_i,
  input wire logic ce_i,
  input wire logic reset_n_i,
  input wire logic phi2_i,
  input wire logic select_hi_first_i,
  input wire logic select_hi_second_i,
  input wire logic select_lo_third_n_i,
  input wire logic reg_select_lo_i,
  input wire logic reg_select_hi_i,
  input wire logic rw_i,
  input wire logic [7:0] data_i,
  output logic [7:0] data_o,
  output logic data_oe_n_o,
  input wire logic [PORT_W-1:0] side_a_port_lines_i,
  output logic [PORT_W-1:0] side_a_port_lines_o,
  output logic [PORT_W-1:0] side_a_port_lines_oe_n_o,
  input wire logic [PORT_W-1:0] side_b_port_lines_i,
  output logic [PORT_W-1:0] side_b_port_lines_o,
  output logic [PORT_W-1:0] side_b_port_lines_oe_n_o,
  input wire logic side_a_int_in_first_i,
  input wire logic side_a_ctl_line_second_i,
  input wire logic side_b_int_in_first_i,
  input wire logic side_b_ctl_line_second_i,
  output logic side_a_int_req_n_o,
  output logic side_a_int_req_oe_n_o,
  output logic side_b_int_req_n_o,
  output logic side_b_int_req_oe_n_o
);

  // ---------------------------------------------------------------
  // Elaboration check
  // ---------------------------------------------------------------
  if (PORT_W != 8) begin : g_bad_width
    $error("pio_adapter: PORT_W must be 8 to match the data bus");
  end

  state_t st;
  state_t st_next;

  // ---------------------------------------------------------------
  // Synchronised views of the pins
  // ---------------------------------------------------------------
  logic phi2_s;
  logic rw_s;
  logic sel_s;
  logic [1:0] rs_s;
  logic [7:0] data_s;
  logic [7:0] pa_s;
  logic [7:0] pb_s;
  logic [NUM_LINES-1:0] lines_s;
  logic [NUM_LINES-1:0] edge_pol;
  logic [NUM_LINES-1:0] line_edge;
  logic phi2_fall;
  logic clr_a;
  logic clr_b;

  assign phi2_s = st.sync2[SY_PHI2];
  assign rw_s = st.sync2[SY_RW];
  assign rs_s = st.sync2[SY_RS+1:SY_RS];
  assign data_s = st.sync2[SY_DATA+7:SY_DATA];
  assign pa_s = st.sync2[SY_PA+7:SY_PA];
  assign pb_s = st.sync2[SY_PB+7:SY_PB];
  assign lines_s = st.sync2[SY_LINES+NUM_LINES-1:SY_LINES];
  assign sel_s = st.sync2[SY_CS_FIRST] & st.sync2[SY_CS_SECOND]
               & ~st.sync2[SY_CS_THIRD_N];
  assign phi2_fall = st.phi2_prev & ~phi2_s;

  // Active edge: 0 falling, 1 rising
  assign edge_pol = {st.ctl_b[CTL_SECOND_EDGE], st.ctl_b[CTL_FIRST_EDGE],
                     st.ctl_a[CTL_SECOND_EDGE], st.ctl_a[CTL_FIRST_EDGE]};

  // ---------------------------------------------------------------
  // Edge detection per event line
  // ---------------------------------------------------------------
  for (genvar i = 0; i < NUM_LINES; i++) begin : g_edge
    assign line_edge[i] = edge_pol[i] ? (lines_s[i] & ~st.line_prev[i])
                                      : (~lines_s[i] & st.line_prev[i]);
  end

  // Selected port-slot reads, taken at the end of the phi2 pulse
  assign clr_a = phi2_fall & st.lat_sel & st.lat_rw
               & (st.lat_rs == SEL_A_SLOT) & st.ctl_a[CTL_SLOT_SEL];
  assign clr_b = phi2_fall & st.lat_sel & st.lat_rw
               & (st.lat_rs == SEL_B_SLOT) & st.ctl_b[CTL_SLOT_SEL];

  // ---------------------------------------------------------------
  // Next state
  // ---------------------------------------------------------------
  always_comb begin
    st_next = st;
    st_next.sync1 = {reset_n_i,
                     side_b_ctl_line_second_i, side_b_int_in_first_i,
                     side_a_ctl_line_second_i, side_a_int_in_first_i,
                     side_b_port_lines_i, side_a_port_lines_i,
                     select_lo_third_n_i, select_hi_second_i,
                     select_hi_first_i, reg_select_hi_i, reg_select_lo_i,
                     rw_i, phi2_i, data_i};
    st_next.sync2 = st.sync1;
    st_next.phi2_prev = phi2_s;
    st_next.line_prev = lines_s;

    // Bus fields held from the last cycle of the phi2 pulse
    if (phi2_s) begin
      st_next.lat_sel = sel_s;
      st_next.lat_rw = rw_s;
      st_next.lat_rs = rs_s;
      st_next.lat_data = data_s;
    end

    // Writes take effect after the falling edge of phi2
    if (phi2_fall && st.lat_sel && !st.lat_rw) begin
      unique case (st.lat_rs)
        SEL_A_SLOT: begin
          if (st.ctl_a[CTL_SLOT_SEL]) begin
            st_next.out_a = st.lat_data;
          end else begin
            st_next.dir_a = st.lat_data;
          end
        end
        SEL_A_CTRL: begin
          st_next.ctl_a[CTL_WR_MSB:0] = st.lat_data[CTL_WR_MSB:0];
        end
        SEL_B_SLOT: begin
          if (st.ctl_b[CTL_SLOT_SEL]) begin
            st_next.out_b = st.lat_data;
          end else begin
            st_next.dir_b = st.lat_data;
          end
        end
        SEL_B_CTRL: begin
          st_next.ctl_b[CTL_WR_MSB:0] = st.lat_data[CTL_WR_MSB:0];
        end
      endcase
    end

    // Flags: a set in the clearing cycle wins
    if (clr_a) begin
      st_next.ctl_a[CTL_FLAG_FIRST] = 1'b0;
      st_next.ctl_a[CTL_FLAG_SECOND] = 1'b0;
    end
    if (clr_b) begin
      st_next.ctl_b[CTL_FLAG_FIRST] = 1'b0;
      st_next.ctl_b[CTL_FLAG_SECOND] = 1'b0;
    end
    if (line_edge[0]) begin
      st_next.ctl_a[CTL_FLAG_FIRST] = 1'b1;
    end
    if (line_edge[1] && !st.ctl_a[CTL_SECOND_MODE]) begin
      st_next.ctl_a[CTL_FLAG_SECOND] = 1'b1;
    end
    if (line_edge[2]) begin
      st_next.ctl_b[CTL_FLAG_FIRST] = 1'b1;
    end
    if (line_edge[3] && !st.ctl_b[CTL_SECOND_MODE]) begin
      st_next.ctl_b[CTL_FLAG_SECOND] = 1'b1;
    end

    // Read data and bus drive, only while selected in phi2
    st_next.dout_oe_n = ~(phi2_s & sel_s & rw_s);
    unique case (rs_s)
      SEL_A_SLOT: begin
        st_next.dout = st.ctl_a[CTL_SLOT_SEL] ? pa_s : st.dir_a;
      end
      SEL_A_CTRL: begin
        st_next.dout = st.ctl_a;
      end
      SEL_B_SLOT: begin
        st_next.dout = st.ctl_b[CTL_SLOT_SEL]
                     ? ((st.out_b & st.dir_b) | (pb_s & ~st.dir_b))
                     : st.dir_b;
      end
      SEL_B_CTRL: begin
        st_next.dout = st.ctl_b;
      end
    endcase

    // Low reset pin clears every device register
    if (!st.sync2[SY_RESET_N]) begin
      st_next.ctl_a = CTRL_RST;
      st_next.ctl_b = CTRL_RST;
      st_next.dir_a = DIR_RST;
      st_next.dir_b = DIR_RST;
      st_next.out_a = OUT_RST;
      st_next.out_b = OUT_RST;
      st_next.lat_sel = 1'b0;
      st_next.dout_oe_n = 1'b1;
    end

    st_next.irq_a_n = ~((st_next.ctl_a[CTL_FLAG_FIRST]
                        & st_next.ctl_a[CTL_FIRST_EN])
                      | (st_next.ctl_a[CTL_FLAG_SECOND]
                        & st_next.ctl_a[CTL_SECOND_EN]));
    st_next.irq_b_n = ~((st_next.ctl_b[CTL_FLAG_FIRST]
                        & st_next.ctl_b[CTL_FIRST_EN])
                      | (st_next.ctl_b[CTL_FLAG_SECOND]
                        & st_next.ctl_b[CTL_SECOND_EN]));
  end

  always_ff @(posedge mclk_i) begin
    if (reset_i) begin
      st <= ST_RST;
    end else if (ce_i) begin
      st <= st_next;
    end
  end

  // ---------------------------------------------------------------
  // Outputs
  // ---------------------------------------------------------------
  assign data_o = st.dout;
  assign data_oe_n_o = st.dout_oe_n;
  assign side_a_port_lines_o = st.out_a;
  assign side_a_port_lines_oe_n_o = ~st.dir_a;
  assign side_b_port_lines_o = st.out_b;
  assign side_b_port_lines_oe_n_o = ~st.dir_b;
  // Open drain: driven low only while asserting
  assign side_a_int_req_n_o = st.irq_a_n;
  assign side_a_int_req_oe_n_o = st.irq_a_n;
  assign side_b_int_req_n_o = st.irq_b_n;
  assign side_b_int_req_oe_n_o = st.irq_b_n;

  // ---------------------------------------------------------------
  // Assertions
  // ---------------------------------------------------------------
  default clocking cb @(posedge mclk_i); endclocking
  default disable iff (reset_i || !ce_i);

  irq_a_level_a: assert property (
    side_a_int_req_oe_n_o
    == !((st.ctl_a[CTL_FLAG_FIRST] && st.ctl_a[CTL_FIRST_EN])
         || (st.ctl_a[CTL_FLAG_SECOND] && st.ctl_a[CTL_SECOND_EN])))
    else $error("side A request does not follow flags and enables");

  portb_hiz_a: assert property (
    phi2_fall && st.lat_sel && !st.lat_rw && st.lat_rs == SEL_B_SLOT
    && !st.ctl_b[CTL_SLOT_SEL] && st.sync2[SY_RESET_N]
    |=> side_b_port_lines_oe_n_o == ~$past(st.lat_data))
    else $error("side B driver enable disagrees with direction");

  flag_a_set_a: assert property (
    line_edge[0] && st.sync2[SY_RESET_N] |=> st.ctl_a[CTL_FLAG_FIRST])
    else $error("side A first flag not set by edge");

  flag_b_set_a: assert property (
    line_edge[3] && !st.ctl_b[CTL_SECOND_MODE] && st.sync2[SY_RESET_N]
    |=> st.ctl_b[CTL_FLAG_SECOND])
    else $error("side B second flag not set by edge");

  rd_clear_a: assert property (
    clr_a && !line_edge[0] && !line_edge[1]
    |=> !st.ctl_a[CTL_FLAG_FIRST] && !st.ctl_a[CTL_FLAG_SECOND])
    else $error("side A flags not cleared by slot read");

  ctrl_write_a: assert property (
    phi2_fall && st.lat_sel && !st.lat_rw && st.lat_rs == SEL_A_CTRL
    && st.sync2[SY_RESET_N]
    |=> st.ctl_a[CTL_WR_MSB:0] == $past(st.lat_data[CTL_WR_MSB:0]))
    else $error("side A control write not applied after phi2 fall");

  dir_write_a: assert property (
    phi2_fall && st.lat_sel && !st.lat_rw && st.lat_rs == SEL_A_SLOT
    && !st.ctl_a[CTL_SLOT_SEL] && st.sync2[SY_RESET_N]
    |=> st.dir_a == $past(st.lat_data))
    else $error("direction write went to wrong register");

  no_drive_a: assert property (
    !sel_s |=> data_oe_n_o)
    else $error("data bus driven while not selected");

  pin_reset_a: assert property (
    !st.sync2[SY_RESET_N] |=> st.ctl_a == CTRL_RST && st.out_b == OUT_RST)
    else $error("reset pin did not clear registers");

  cov_irq_a_c: cover property (!side_a_int_req_oe_n_o);
  cov_clear_b_c: cover property (clr_b ##1 !st.ctl_b[CTL_FLAG_FIRST]);
  cov_write_out_b_c: cover property (phi2_fall && st.lat_sel
    && !st.lat_rw && st.lat_rs == SEL_B_SLOT);
  cov_read_c: cover property (!data_oe_n_o);

endmodule

`default_nettype wire

// File: src/pio_adapter_pkg.sv
// Constants and state type for the dual port parallel I/O adapter
package pio_adapter_pkg;

  // ---------------------------------------------------------------
  // Register select codes
  // ---------------------------------------------------------------
  localparam logic [1:0] SEL_A_SLOT = 2'h0;
  localparam logic [1:0] SEL_A_CTRL = 2'h1;
  localparam logic [1:0] SEL_B_SLOT = 2'h2;
  localparam logic [1:0] SEL_B_CTRL = 2'h3;

  // ---------------------------------------------------------------
  // Control register fields
  // ---------------------------------------------------------------
  localparam int CTL_FIRST_EN = 0;
  localparam int CTL_FIRST_EDGE = 1;
  localparam int CTL_SLOT_SEL = 2;
  localparam int CTL_SECOND_EN = 3;
  localparam int CTL_SECOND_EDGE = 4;
  localparam int CTL_SECOND_MODE = 5;
  localparam int CTL_FLAG_SECOND = 6;
  localparam int CTL_FLAG_FIRST = 7;
  localparam int CTL_WR_MSB = 5;

  // ---------------------------------------------------------------
  // Reset values
  // ---------------------------------------------------------------
  localparam logic [7:0] CTRL_RST = 8'h00;
  localparam logic [7:0] DIR_RST = 8'h00;
  localparam logic [7:0] OUT_RST = 8'h00;

  // ---------------------------------------------------------------
  // Layout of the synchronised pin vector
  // ---------------------------------------------------------------
  localparam int SY_DATA = 0;
  localparam int SY_PHI2 = 8;
  localparam int SY_RW = 9;
  localparam int SY_RS = 10;
  localparam int SY_CS_FIRST = 12;
  localparam int SY_CS_SECOND = 13;
  localparam int SY_CS_THIRD_N = 14;
  localparam int SY_PA = 15;
  localparam int SY_PB = 23;
  localparam int SY_LINES = 31;
  localparam int SY_RESET_N = 35;
  localparam int SYNC_W = 36;
  localparam logic [SYNC_W-1:0] SYNC_RST = 36'h800000000;

  // Event lines: 0 side A first, 1 side A second, 2 side B first,
  // 3 side B second
  localparam int NUM_LINES = 4;

  // ---------------------------------------------------------------
  // Module state
  // ---------------------------------------------------------------
  typedef struct packed {
    logic [SYNC_W-1:0] sync1;
    logic [SYNC_W-1:0] sync2;
    logic phi2_prev;
    logic [NUM_LINES-1:0] line_prev;
    logic lat_sel;
    logic lat_rw;
    logic [1:0] lat_rs;
    logic [7:0] lat_data;
    logic [7:0] ctl_a;
    logic [7:0] ctl_b;
    logic [7:0] dir_a;
    logic [7:0] dir_b;
    logic [7:0] out_a;
    logic [7:0] out_b;
    logic [7:0] dout;
    logic dout_oe_n;
    logic irq_a_n;
    logic irq_b_n;
  } state_t;

  localparam state_t ST_RST = '{
    sync1: SYNC_RST,
    sync2: SYNC_RST,
    phi2_prev: 1'b0,
    line_prev: 4'h0,
    lat_sel: 1'b0,
    lat_rw: 1'b1,
    lat_rs: 2'h0,
    lat_data: 8'h00,
    ctl_a: CTRL_RST,
    ctl_b: CTRL_RST,
    dir_a: DIR_RST,
    dir_b: DIR_RST,
    out_a: OUT_RST,
    out_b: OUT_RST,
    dout: 8'h00,
    dout_oe_n: 1'b1,
    irq_a_n: 1'b1,
    irq_b_n: 1'b1
  };

endpackage

// File: testbench/pio_far_side.sv
// Peripheral side model: port pin resolution and request wire pull-ups
`timescale 1ns/1ps
`default_nettype none

module pio_far_side (
  input wire logic [7:0] a_o_i,
  input wire logic [7:0] a_oe_n_i,
  input wire logic [7:0] b_o_i,
  input wire logic [7:0] b_oe_n_i,
  input wire logic [7:0] ext_a_i,
  input wire logic [7:0] ext_b_i,
  input wire logic [7:0] load_i,
  input wire logic irq_a_oe_n_i,
  input wire logic irq_b_oe_n_i,
  input wire logic irq_a_n_i,
  input wire logic irq_b_n_i,
  output logic [7:0] pa_pin_o,
  output logic [7:0] pb_pin_o,
  output logic [1:0] irq_wire_o
);
  // Loaded output lines cannot reach a high level on the pin
  assign pa_pin_o = (~a_oe_n_i & a_o_i & ~load_i) | (a_oe_n_i & ext_a_i);
  assign pb_pin_o = (~b_oe_n_i & b_o_i & ~load_i) | (b_oe_n_i & ext_b_i);
  // Open-drain request lines with a pull-up: low only when enabled and low
  assign irq_wire_o = {irq_b_oe_n_i | irq_b_n_i,
                       irq_a_oe_n_i | irq_a_n_i};
endmodule

`default_nettype wire

// File: testbench/tb.sv
// Self-checking bench for the dual port parallel I/O adapter
`timescale 1ns/1ps
`default_nettype none

module tb;
  import pio_adapter_pkg::*;
  logic mclk = 1'b0;
  logic reset = 1'b1;
  logic rst_n = 1'b1;
  logic phi2 = 1'b0;
  logic [2:0] cs = 3'h0;
  logic rs_lo = 1'b0;
  logic rs_hi = 1'b0;
  logic rw = 1'b1;
  logic [7:0] din = 8'h00;
  logic [3:0] ev = 4'h0;
  logic [7:0] ext_a = 8'h3C;
  logic [7:0] ext_b = 8'hC3;
  logic [7:0] load = 8'h22;
  logic [7:0] rdq;
  logic rd_oe;
  int mismatches = 0;
  int n_checks = 0;
  int cycles = 0;
  wire logic [7:0] a_o, a_oe_n, b_o, b_oe_n, pa_pin, pb_pin, dq;
  wire logic dq_oe_n, side_a_int_req_n_oe_n, side_b_int_req_n_oe_n, side_a_int_req_n_n, side_b_int_req_n_n;
  wire logic [1:0] irq_w;

  always #2 mclk = ~mclk;

  pio_adapter u_pio_adapter (
    .mclk_i(mclk), .reset_i(reset), .ce_i(1'b1), .reset_n_i(rst_n),
    .phi2_i(phi2), .select_hi_first_i(cs[0]), .select_hi_second_i(cs[1]),
    .select_lo_third_n_i(~cs[2]), .reg_select_lo_i(rs_lo),
    .reg_select_hi_i(rs_hi), .rw_i(rw), .data_i(din), .data_o(dq),
    .data_oe_n_o(dq_oe_n), .side_a_port_lines_i(pa_pin),
    .side_a_port_lines_o(a_o), .side_a_port_lines_oe_n_o(a_oe_n),
    .side_b_port_lines_i(pb_pin), .side_b_port_lines_o(b_o),
    .side_b_port_lines_oe_n_o(b_oe_n), .side_a_int_in_first_i(ev[0]),
    .side_a_ctl_line_second_i(ev[1]), .side_b_int_in_first_i(ev[2]),
    .side_b_ctl_line_second_i(ev[3]), .side_a_int_req_n_o(side_a_int_req_n_n),
    .side_a_int_req_oe_n_o(side_a_int_req_n_oe_n), .side_b_int_req_n_o(side_b_int_req_n_n),
    .side_b_int_req_oe_n_o(side_b_int_req_n_oe_n)
  );

  pio_far_side u_pio_far_side (
    .a_o_i(a_o), .a_oe_n_i(a_oe_n), .b_o_i(b_o), .b_oe_n_i(b_oe_n),
    .ext_a_i(ext_a), .ext_b_i(ext_b), .load_i(load),
    .irq_a_oe_n_i(side_a_int_req_n_oe_n), .irq_b_oe_n_i(side_b_int_req_n_oe_n),
    .irq_a_n_i(side_a_int_req_n_n), .irq_b_n_i(side_b_int_req_n_n),
    .pa_pin_o(pa_pin), .pb_pin_o(pb_pin), .irq_wire_o(irq_w)
  );

  // ---------------------------------------------------------------
  // Shared tasks
  // ---------------------------------------------------------------
  task automatic stop_test();
    $display("checks %0d mismatches %0d", n_checks, mismatches);
    if (mismatches == 0 && n_checks > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask

  task automatic check(input logic [7:0] got, input logic [7:0] exp);
    n_checks++;
    if (got !== exp) begin
      mismatches++;
      $display("[FAIL] t=%0t got %h exp %h", $time, got, exp);
    end
  endtask

  task automatic idle(input int n);
    repeat (n) @(posedge mclk);
    #1;
  endtask

  // One phi2 cycle; fields held through five clocks past the fall
  task automatic bus(input logic [1:0] rs, input logic rd,
                     input logic [7:0] d, input logic [2:0] ok);
    @(posedge mclk);
    #1;
    phi2 = 1'b1;
    cs = ok;
    rs_hi = rs[1];
    rs_lo = rs[0];
    rw = rd;
    din = d;
    idle(5);
    // Released bus shows the inverse of the last value
    rdq = dq_oe_n ? ~dq : dq;
    rd_oe = dq_oe_n;
    phi2 = 1'b0;
    idle(5);
    cs = 3'h0;
    rw = 1'b1;
    din = ~d;
  endtask

  task automatic wr(input logic [1:0] rs, input logic [7:0] d);
    bus(rs, 1'b0, d, 3'h7);
  endtask

  task automatic rd(input logic [1:0] rs, input logic [7:0] exp);
    bus(rs, 1'b1, 8'hFF, 3'h7);
    check(rdq, exp);
  endtask

  // ---------------------------------------------------------------
  // Scenarios
  // ---------------------------------------------------------------
  task automatic t_reset();
    rd(SEL_A_CTRL, 8'h00);
    rd(SEL_B_CTRL, 8'h00);
    rd(SEL_A_SLOT, 8'h00);
    rd(SEL_B_SLOT, 8'h00);
    check(a_oe_n, 8'hFF);
    check({6'h00, irq_w}, 8'h03);
    $display("test reset done");
  endtask

  task automatic t_ports();
    wr(SEL_A_SLOT, 8'hF0);
    wr(SEL_A_CTRL, 8'h04);
    wr(SEL_A_SLOT, 8'hA5);
    wr(SEL_B_SLOT, 8'h0F);
    wr(SEL_B_CTRL, 8'h04);
    wr(SEL_B_SLOT, 8'h5A);
    check(a_oe_n, 8'h0F);
    check(a_o, 8'hA5);
    check(b_oe_n, 8'hF0);
    check(b_o, 8'h5A);
    rd(SEL_A_SLOT, 8'h8C);
    rd(SEL_B_SLOT, 8'hCA);
    rd(SEL_A_CTRL, 8'h04);
    wr(SEL_A_CTRL, 8'h00);
    rd(SEL_A_SLOT, 8'hF0);
    wr(SEL_B_CTRL, 8'h00);
    rd(SEL_B_SLOT, 8'h0F);
    $display("test ports done");
  endtask

  task automatic t_events();
    int ln;
    logic [1:0] slot;
    logic [7:0] c, en, fl;
    for (int s = 0; s < 2; s++) begin
      for (int k = 0; k < 2; k++) begin
        for (int p = 0; p < 2; p++) begin
          ln = s * 2 + k;
          slot = s[0] ? SEL_B_SLOT : SEL_A_SLOT;
          en = k[0] ? 8'h08 : 8'h01;
          fl = k[0] ? 8'h40 : 8'h80;
          c = 8'h04 | en | (k[0] ? {3'h0, p[0], 4'h0} : {6'h0, p[0], 1'b0});
          ev[ln] = p[0];
          wr(slot | 2'h1, c ^ en);
          bus(slot, 1'b1, 8'hFF, 3'h7);
          ev[ln] = ~p[0];
          idle(8);
          rd(slot | 2'h1, c ^ en);
          ev[ln] = p[0];
          idle(8);
          rd(slot | 2'h1, (c ^ en) | fl);
          check({7'h00, irq_w[s]}, 8'h01);
          wr(slot | 2'h1, c);
          check({7'h00, irq_w[s]}, 8'h00);
          bus(slot, 1'b1, 8'hFF, 3'h7);
          check({7'h00, irq_w[s]}, 8'h01);
          rd(slot | 2'h1, c);
        end
      end
    end
    $display("test events done");
  endtask

  task automatic t_select();
    wr(SEL_A_CTRL, 8'h05);
    bus(SEL_A_CTRL, 1'b0, 8'h3A, 3'h6);
    rd(SEL_A_CTRL, 8'h05);
    bus(SEL_A_CTRL, 1'b0, 8'h3A, 3'h3);
    rd(SEL_A_CTRL, 8'h05);
    bus(SEL_A_CTRL, 1'b1, 8'hFF, 3'h5);
    check({7'h00, rd_oe}, 8'h01);
    wr(SEL_A_CTRL, 8'hFF);
    rd(SEL_A_CTRL, 8'h3F);
    // Second line in output mode must not raise its flag
    ev[1] = 1'b0;
    idle(8);
    ev[1] = 1'b1;
    idle(8);
    rd(SEL_A_CTRL, 8'h3F);
    $display("test select done");
  endtask

  task automatic t_reset_pin();
    wr(SEL_B_CTRL, 8'h00);
    wr(SEL_B_SLOT, 8'hFF);
    rst_n = 1'b0;
    idle(8);
    rst_n = 1'b1;
    idle(6);
    rd(SEL_A_CTRL, 8'h00);
    check(b_oe_n, 8'hFF);
    $display("test reset pin done");
  endtask

  always @(posedge mclk) begin
    cycles++;
    if (cycles == 20000) begin
      mismatches++;
      stop_test();
    end
  end

  initial begin
    idle(3);
    reset = 1'b0;
    idle(6);
    t_reset();
    t_ports();
    t_events();
    t_select();
    t_reset_pin();
    stop_test();
  end
endmodule

`default_nettype wire
